// file: core/timer16_wave_ctrl.sv
/*
 * 16-bit timer with waveform generation and compare output control,
 * reached over APB. Assumes an APB master on clk_i and port logic that
 * resolves each pin from the level and output enable given here.
 */
// Register access over APB is this design's own decision.
`timescale 1ns/100ps

module timer16_wave_ctrl (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // waveform pins
   output timer16_pkg::pin_drive_t wave_out_a_o,
   output timer16_pkg::pin_drive_t wave_out_b_o,
   // interrupt
   output logic irq_o
);
   import timer16_pkg::*;

   // =====================================================================
   // decode helpers

   // family of a waveform mode; reserved mode falls back to non-PWM
   function automatic family_t family_of(input logic [3:0] m);
      family_t f;
      f = FAM_NONPWM;
      case (m)
         4'h1, 4'h2, 4'h3, MODE_PFC_CAP, MODE_PFC_A, MODE_PC_CAP, MODE_PC_A: begin
            f = FAM_DUAL;
         end
         4'h5, 4'h6, 4'h7, MODE_FAST_CAP, MODE_FAST_A: begin
            f = FAM_FAST;
         end
         default: begin
            f = FAM_NONPWM;
         end
      endcase
      return f;
   endfunction

   // TOP value of a waveform mode
   function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmp_a,
                                          input logic [15:0] cap);
      logic [15:0] t;
      t = COUNT_MAX;
      case (m)
         4'h1, 4'h5: t = TOP_8BIT;
         4'h2, 4'h6: t = TOP_9BIT;
         4'h3, 4'h7: t = TOP_10BIT;
         MODE_CTC_A, MODE_PFC_A, MODE_PC_A, MODE_FAST_A: t = cmp_a;
         MODE_PFC_CAP, MODE_PC_CAP, MODE_CTC_CAP, MODE_FAST_CAP: t = cap;
         default: t = COUNT_MAX;
      endcase
      return t;
   endfunction

   // next waveform level for one channel
   function automatic logic wave_step(input logic cur, input logic [1:0] om,
                                      input family_t fam, input logic match,
                                      input logic bottom, input logic down,
                                      input logic tog_ok, input logic cmp_is_top);
      logic r;
      r = cur;
      case (fam)
         FAM_FAST: begin
            if (om[1]) begin
               if (bottom) r = ~om[0];
               if (match && !cmp_is_top) r = om[0];
            end else if (om == OM_TOGGLE && tog_ok && match) begin
               r = ~cur;
            end
         end
         FAM_DUAL: begin
            if (om[1] && match) r = down ? ~om[0] : om[0];
            else if (om == OM_TOGGLE && tog_ok && match) r = ~cur;
         end
         default: begin
            if (match && om == OM_TOGGLE) r = ~cur;
            else if (match && om[1]) r = om[0];
         end
      endcase
      return r;
   endfunction

   // whether a channel owns its pin
   function automatic logic connected(input logic [1:0] om, input family_t fam,
                                      input logic tog_ok);
      return (om != OM_OFF) && !(om == OM_TOGGLE && fam != FAM_NONPWM && !tog_ok);
   endfunction

   // =====================================================================
   // registers
   logic [7:0] wave_ctrl_reg;
   logic [7:0] mode_ctrl_reg;
   logic [15:0] cmp_a_buf_reg;
   logic [15:0] cmp_b_buf_reg;
   logic [15:0] cmp_a_reg;
   logic [15:0] cmp_b_reg;
   logic [15:0] capture_reg;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic down_reg;
   logic down_next;
   logic [2:0] status_reg;
   logic [2:0] status_next;
   logic [2:0] mask_reg;
   logic [3:0] port_reg;
   logic wave_a_reg;
   logic wave_b_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic irq_reg;
   pin_drive_t pin_a_reg;
   pin_drive_t pin_b_reg;

   // =====================================================================
   // apb decode
   wire access = psel_i & penable_i;
   wire first_cycle = access & ~pready_reg;
   wire wr_fire = access & pready_reg & pwrite_i;
   wire hit = paddr_i == WAVE_CTRL_OFS || paddr_i == MODE_CTRL_OFS ||
              paddr_i == CMP_A_OFS || paddr_i == CMP_B_OFS ||
              paddr_i == CAPTURE_OFS || paddr_i == COUNT_OFS ||
              paddr_i == IRQ_STATUS_OFS || paddr_i == IRQ_MASK_OFS ||
              paddr_i == PORT_CTRL_OFS;
   wire wr_wave = wr_fire & (paddr_i == WAVE_CTRL_OFS);
   wire wr_mode = wr_fire & (paddr_i == MODE_CTRL_OFS);
   wire wr_cmp_a = wr_fire & (paddr_i == CMP_A_OFS);
   wire wr_cmp_b = wr_fire & (paddr_i == CMP_B_OFS);
   wire wr_cap = wr_fire & (paddr_i == CAPTURE_OFS);
   wire wr_count = wr_fire & (paddr_i == COUNT_OFS);
   wire wr_status = wr_fire & (paddr_i == IRQ_STATUS_OFS);
   wire wr_mask = wr_fire & (paddr_i == IRQ_MASK_OFS);
   wire wr_port = wr_fire & (paddr_i == PORT_CTRL_OFS);

   // =====================================================================
   // mode decode, combinational so a write acts on the next tick
   // direct decode of fields
   wire [1:0] om_a = wave_ctrl_reg[CHA_MODE_LSB +: 2];
   wire [1:0] om_b = wave_ctrl_reg[CHB_MODE_LSB +: 2];
   wire [3:0] wgm = {mode_ctrl_reg[WGM_HIGH_LSB +: 2], wave_ctrl_reg[WGM_LOW_LSB +: 2]};
   wire family_t fam = family_of(wgm);
   wire [15:0] top = top_of(wgm, cmp_a_reg, capture_reg);
   wire tick = mode_ctrl_reg[RUN_BIT];
   wire at_top = count_reg == top;
   wire at_bottom = count_reg == COUNT_BOTTOM;
   // toggle of A only in these modes
   wire tog_ok_a = (fam == FAM_FAST) ? (wgm == MODE_FAST_CAP || wgm == MODE_FAST_A) :
                   (wgm == MODE_PFC_A || wgm == MODE_PC_A);
   // TOP counts as down slope, BOTTOM as up slope
   wire slope_down = at_top | (down_reg & ~at_bottom);

   // =====================================================================
   // counter sequence
   // dual slope holds TOP one tick, then reverses
   always_comb begin
      count_next = count_reg;
      down_next = down_reg;
      if (wr_count) begin
         count_next = pwdata_i[15:0];
      end else if (tick) begin
         if (fam == FAM_DUAL) begin
            if (!down_reg && at_top) begin
               down_next = 1'b1;
               count_next = count_reg - 16'h0001;
            end else if (down_reg && at_bottom) begin
               down_next = 1'b0;
               count_next = count_reg + 16'h0001;
            end else begin
               count_next = down_reg ? count_reg - 16'h0001 : count_reg + 16'h0001;
            end
         end else begin
            down_next = 1'b0;
            count_next = at_top ? COUNT_BOTTOM : count_reg + 16'h0001;
         end
      end
   end

   // =====================================================================
   // compare reload and events
   // reload point per mode
   wire reload_at_top = wgm == 4'h1 || wgm == 4'h2 || wgm == 4'h3 ||
                        wgm == MODE_PC_CAP || wgm == MODE_PC_A;
   wire reload = (fam == FAM_NONPWM) ||
                 (tick && (reload_at_top ? at_top : at_bottom));
   wire match_a = tick & (count_reg == cmp_a_reg);
   wire match_b = tick & (count_reg == cmp_b_reg);
   wire overflow = tick & ((fam == FAM_NONPWM) ? (count_reg == COUNT_MAX) :
                           (fam == FAM_FAST) ? at_top : (at_bottom & down_reg));
   wire [2:0] events = {match_b, match_a, overflow};
   // a flag raised in the clearing cycle survives the clear
   assign status_next = (status_reg & ~(wr_status ? pwdata_i[2:0] : 3'h0)) | events;

   // =====================================================================
   // waveform levels
   // channel actions
   wire wave_a_next = wave_step(wave_a_reg, om_a, fam, match_a, tick & at_bottom,
                                slope_down, tog_ok_a, cmp_a_reg == top);
   // channel B never toggles in PWM families
   wire wave_b_next = wave_step(wave_b_reg, om_b, fam, match_b, tick & at_bottom,
                                slope_down, 1'b0, cmp_b_reg == top);
   wire own_a = connected(om_a, fam, tog_ok_a);
   wire own_b = connected(om_b, fam, 1'b0);
   wire pin_drive_t pin_a_next = '{level: own_a ? wave_a_next : port_reg[DATA_A_BIT],
                                   oe: port_reg[DIR_A_BIT]};
   wire pin_drive_t pin_b_next = '{level: own_b ? wave_b_next : port_reg[DATA_B_BIT],
                                   oe: port_reg[DIR_B_BIT]};

   // =====================================================================
   // read data mux, unmapped reads return zero
   // reserved control bits read zero
   wire [31:0] rd_data =
      (paddr_i == WAVE_CTRL_OFS) ? {24'h000000, wave_ctrl_reg & WAVE_CTRL_WMASK} :
      (paddr_i == MODE_CTRL_OFS) ? {24'h000000, mode_ctrl_reg} :
      (paddr_i == CMP_A_OFS) ? {16'h0000, cmp_a_buf_reg} :
      (paddr_i == CMP_B_OFS) ? {16'h0000, cmp_b_buf_reg} :
      (paddr_i == CAPTURE_OFS) ? {16'h0000, capture_reg} :
      (paddr_i == COUNT_OFS) ? {16'h0000, count_reg} :
      (paddr_i == IRQ_STATUS_OFS) ? {29'h0, status_reg} :
      (paddr_i == IRQ_MASK_OFS) ? {29'h0, mask_reg} :
      (paddr_i == PORT_CTRL_OFS) ? {28'h0000000, port_reg} : 32'h00000000;

   // =====================================================================
   // apb handshake: one wait state, answer in the second access cycle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= first_cycle;
         pslverr_reg <= first_cycle & ~hit;
         prdata_reg <= first_cycle ? rd_data : 32'h00000000;
      end
   end

   // =====================================================================
   // control registers
   // writable fields reset to zero, wave control bits 3:2 never stored
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wave_ctrl_reg <= WAVE_CTRL_RESET;
         mode_ctrl_reg <= MODE_CTRL_RESET;
         mask_reg <= 3'h0;
         port_reg <= 4'h0;
      end else begin
         if (wr_wave) wave_ctrl_reg <= pwdata_i[7:0] & WAVE_CTRL_WMASK;
         if (wr_mode) mode_ctrl_reg <= pwdata_i[7:0] & MODE_CTRL_WMASK;
         if (wr_mask) mask_reg <= pwdata_i[2:0];
         if (wr_port) port_reg <= pwdata_i[3:0];
      end
   end

   // =====================================================================
   // compare buffers and active compare values
   // immediate reload in non-PWM modes
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cmp_a_buf_reg <= WORD_RESET;
         cmp_b_buf_reg <= WORD_RESET;
         cmp_a_reg <= WORD_RESET;
         cmp_b_reg <= WORD_RESET;
         capture_reg <= WORD_RESET;
      end else begin
         if (wr_cmp_a) cmp_a_buf_reg <= pwdata_i[15:0];
         if (wr_cmp_b) cmp_b_buf_reg <= pwdata_i[15:0];
         if (wr_cap) capture_reg <= pwdata_i[15:0];
         if (reload) cmp_a_reg <= cmp_a_buf_reg;
         if (reload) cmp_b_reg <= cmp_b_buf_reg;
      end
   end

   // =====================================================================
   // counter, waveform and status state
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_reg <= WORD_RESET;
         down_reg <= 1'b0;
         wave_a_reg <= 1'b0;
         wave_b_reg <= 1'b0;
         status_reg <= 3'h0;
      end else begin
         count_reg <= count_next;
         down_reg <= down_next;
         wave_a_reg <= wave_a_next;
         wave_b_reg <= wave_b_next;
         status_reg <= status_next;
      end
   end

   // =====================================================================
   // pins and interrupt, registered so outputs come from flops
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_a_reg <= '{level: 1'b0, oe: 1'b0};
         pin_b_reg <= '{level: 1'b0, oe: 1'b0};
         irq_reg <= 1'b0;
      end else begin
         pin_a_reg <= pin_a_next;
         pin_b_reg <= pin_b_next;
         irq_reg <= |(status_next & mask_reg);
      end
   end

   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign wave_out_a_o = pin_a_reg;
   assign wave_out_b_o = pin_b_reg;
   assign irq_o = irq_reg;

endmodule // timer16_wave_ctrl

// file: shared/timer16_pkg.sv
/*
 * Constants, field layout and carrier types of the 16-bit timer waveform
 * output control block. Assumes a single 20 MHz clock and an APB master
 * with 32-bit data; each register takes one aligned word.
 */
// Summary of operation
// - Nonzero channel A output-mode lets waveform A take over its pin.
// - Nonzero channel B output-mode lets waveform B take over its pin.
// - Pin driver is enabled only while its direction bit is set.
// - Output-mode meaning depends on non-PWM, fast or dual-slope family.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clear on match, set at bottom; 11 inverse.
// - Fast PWM 01 toggles A only in modes 14/15; else disconnected.
// - Fast PWM: match at compare equal TOP ignored; bottom action kept.
// - Dual-slope: 10 clears on up match, sets on down match; 11 inverse.
// - Dual-slope 01 toggles A only in modes 9/11; else disconnected.
// - Mode is low two bits here plus two high bits; 13 reserved.
// - Modes 0, 4, 12: TOP fixed/A/capture, immediate update, overflow at MAX.
// - Modes 1-3, 5-7: fixed TOPs; dual update at TOP, fast at BOTTOM.
// - Modes 8-11: TOP from capture/A; overflow BOTTOM; reload BOTTOM or TOP.
// - Modes 14/15: fast PWM, TOP capture/A, reload BOTTOM, overflow TOP.
// - Dual-slope: compare at BOTTOM gives constant low, at TOP high.
// - Dual-slope counts 0 up to TOP, holds TOP one tick, then down.
package timer16_pkg;

   // =====================================================================
   // register offsets (byte addresses)
   localparam logic [11:0] WAVE_CTRL_OFS = 12'h080;
   localparam logic [11:0] MODE_CTRL_OFS = 12'h084;
   localparam logic [11:0] CMP_A_OFS = 12'h088;
   localparam logic [11:0] CMP_B_OFS = 12'h08c;
   localparam logic [11:0] CAPTURE_OFS = 12'h090;
   localparam logic [11:0] COUNT_OFS = 12'h094;
   localparam logic [11:0] IRQ_STATUS_OFS = 12'h098;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h09c;
   localparam logic [11:0] PORT_CTRL_OFS = 12'h0a0;

   // =====================================================================
   // field positions and reset values
   localparam int CHA_MODE_LSB = 6;
   localparam int CHB_MODE_LSB = 4;
   localparam int WGM_LOW_LSB = 0;
   localparam int WGM_HIGH_LSB = 3;
   localparam int RUN_BIT = 0;
   localparam int IRQ_OVF_BIT = 0;
   localparam int IRQ_MATCH_A_BIT = 1;
   localparam int IRQ_MATCH_B_BIT = 2;
   localparam int DIR_A_BIT = 0;
   localparam int DIR_B_BIT = 1;
   localparam int DATA_A_BIT = 2;
   localparam int DATA_B_BIT = 3;
   localparam logic [7:0] WAVE_CTRL_RESET = 8'h00;
   localparam logic [7:0] WAVE_CTRL_WMASK = 8'hf3;
   localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_CTRL_WMASK = 8'h19;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // =====================================================================
   // counter limits and waveform modes
   localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   localparam logic [3:0] MODE_CTC_A = 4'h4;
   localparam logic [3:0] MODE_PFC_CAP = 4'h8;
   localparam logic [3:0] MODE_PFC_A = 4'h9;
   localparam logic [3:0] MODE_PC_CAP = 4'ha;
   localparam logic [3:0] MODE_PC_A = 4'hb;
   localparam logic [3:0] MODE_CTC_CAP = 4'hc;
   localparam logic [3:0] MODE_RESERVED = 4'hd;
   localparam logic [3:0] MODE_FAST_CAP = 4'he;
   localparam logic [3:0] MODE_FAST_A = 4'hf;

   // output-mode codes
   localparam logic [1:0] OM_OFF = 2'h0;
   localparam logic [1:0] OM_TOGGLE = 2'h1;

   typedef enum logic [1:0] {FAM_NONPWM, FAM_FAST, FAM_DUAL} family_t;

   // one waveform pin: level and output enable
   typedef struct packed {
      logic level;
      logic oe;
   } pin_drive_t;

endpackage

// file: verification/port_pin_model.sv
/*
 * Behavioural pad of one waveform pin on the port side.
 * Assumes the level/oe pair from the timer; the pad has no pull resistor.
 */
`timescale 1ns/100ps

module port_pin_model (
   // clock
   input wire logic clk_i,
   // drive from the block
   input wire timer16_pkg::pin_drive_t drive_i,
   // pad level
   output logic pin_o
);
   import timer16_pkg::*;
   logic last_reg = 1'b0;
   // =====================================================================
   // pad resolution
   // driven only with oe
   // a floating pad flips every cycle so a stale level never passes as driven
   assign pin_o = drive_i.oe ? drive_i.level : ~last_reg;
   always_ff @(posedge clk_i) begin
      last_reg <= pin_o;
   end
endmodule // port_pin_model

// file: verification/tb_top.sv
/*
 * Self-checking bench: register table, duty of waveform modes 1, 4, 5, 8-12, 14 and 15, interrupt, reset.
 * Assumes the APB map and one-wait-state timing of the timer waveform block.
 */
`timescale 1ns/100ps

module tb_top;
   import timer16_pkg::*;
   typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} reg_row_t;
   typedef struct {logic [3:0] m; logic [1:0] c; logic [15:0] cmp; logic [15:0] cap;
      int win; int ea; int eb;} wave_row_t;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   pin_drive_t out_a;
   pin_drive_t out_b;
   logic pin_a;
   logic pin_b;
   logic [31:0] rd;
   logic er;
   int ha;
   int hb;
   int failures = 0;
   int checks_done = 0;
   logic [11:0] offs[9] = '{WAVE_CTRL_OFS, MODE_CTRL_OFS, CMP_A_OFS, CMP_B_OFS, CAPTURE_OFS,
      COUNT_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS, PORT_CTRL_OFS};
   reg_row_t regs[10] = '{
      '{WAVE_CTRL_OFS, 32'hffffffff, 32'h000000f3, 1'b0},
      '{WAVE_CTRL_OFS, 32'h0, 32'h0, 1'b0},
      '{MODE_CTRL_OFS, 32'hffffffff, 32'h00000019, 1'b0},
      '{MODE_CTRL_OFS, 32'h0, 32'h0, 1'b0},
      '{CMP_A_OFS, 32'habcd1234, 32'h00001234, 1'b0},
      '{CMP_B_OFS, 32'hffff5678, 32'h00005678, 1'b0},
      '{CAPTURE_OFS, 32'hffff9abc, 32'h00009abc, 1'b0},
      '{IRQ_MASK_OFS, 32'hffffffff, 32'h00000007, 1'b0},
      '{IRQ_MASK_OFS, 32'h0, 32'h0, 1'b0},
      '{12'h0fc, 32'h1, 32'h0, 1'b1}};
   // mode, output mode, compare, capture, window, high cycles a, high cycles b
   wave_row_t waves[19] = '{
      '{4'h4, 2'h1, 16'h9, 16'h0, 40, 20, 20},
      '{4'h4, 2'h3, 16'h9, 16'h0, 40, 40, 40},
      '{4'h4, 2'h2, 16'h9, 16'h0, 40, 0, 0},
      '{4'hc, 2'h1, 16'h9, 16'h9, 40, 20, 20},
      '{4'he, 2'h2, 16'h4, 16'h13, 40, 8, 8},
      '{4'he, 2'h3, 16'h4, 16'h13, 40, 32, 32},
      '{4'he, 2'h1, 16'h4, 16'h13, 40, 20, 0},
      '{4'he, 2'h2, 16'h13, 16'h13, 40, 40, 40},
      '{4'hf, 2'h1, 16'h13, 16'h0, 40, 20, 0},
      '{4'h5, 2'h1, 16'h4, 16'h0, 40, 40, 0},
      '{4'ha, 2'h2, 16'h3, 16'h8, 32, 12, 12},
      '{4'ha, 2'h3, 16'h3, 16'h8, 32, 20, 20},
      '{4'ha, 2'h2, 16'h0, 16'h8, 32, 0, 0},
      '{4'ha, 2'h2, 16'h8, 16'h8, 32, 32, 32},
      '{4'ha, 2'h1, 16'h3, 16'h8, 32, 32, 0},
      '{4'h9, 2'h1, 16'h8, 16'h0, 32, 16, 0},
      '{4'hb, 2'h1, 16'h8, 16'h0, 32, 16, 0},
      '{4'h8, 2'h2, 16'h3, 16'h8, 32, 12, 12},
      '{4'h1, 2'h2, 16'h3, 16'h0, 1020, 12, 12}};

   // =====================================================================
   // clock, design and pads
   always #25 clk_i = ~clk_i;
   timer16_wave_ctrl timer16_wave_ctrl_i (.clk_i(clk_i), .resetn_i(resetn_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .wave_out_a_o(out_a), .wave_out_b_o(out_b), .irq_o(irq));
   port_pin_model port_pin_model_a_i (.clk_i(clk_i), .drive_i(out_a), .pin_o(pin_a));
   port_pin_model port_pin_model_b_i (.clk_i(clk_i), .drive_i(out_b), .pin_o(pin_b));

   // =====================================================================
   // tasks
   // one transfer; request held until pready is seen at an edge, then one idle cycle
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // high cycles of both pads over a window
   task automatic measure(input int win);
      ha = 0;
      hb = 0;
      repeat (win) begin
         @(posedge clk_i);
         ha += int'(pin_a === 1'b1);
         hb += int'(pin_b === 1'b1);
      end
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // =====================================================================
   // watchdog: the whole run needs well under 8000 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      tally_and_finish();
   end

   // =====================================================================
   // main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      foreach (regs[i]) begin
         apb(1'b1, regs[i].a, regs[i].w);
         check({31'h0, er}, {31'h0, regs[i].e});
         apb(1'b0, regs[i].a, 32'h0);
         check(rd, regs[i].r);
         check({31'h0, er}, {31'h0, regs[i].e});
      end
      // both directions out, port data a high and b low
      apb(1'b1, PORT_CTRL_OFS, 32'h00000007);
      foreach (waves[i]) begin
         apb(1'b1, MODE_CTRL_OFS, {27'h0, waves[i].m[3:2], 3'h0});
         apb(1'b1, COUNT_OFS, 32'h0);
         apb(1'b1, CAPTURE_OFS, {16'h0, waves[i].cap});
         apb(1'b1, CMP_A_OFS, {16'h0, waves[i].cmp});
         apb(1'b1, CMP_B_OFS, {16'h0, waves[i].cmp});
         apb(1'b1, WAVE_CTRL_OFS, {24'h0, waves[i].c, waves[i].c, 2'h0, waves[i].m[1:0]});
         apb(1'b1, MODE_CTRL_OFS, {27'h0, waves[i].m[3:2], 3'h1});
         repeat (waves[i].win) @(posedge clk_i);
         measure(waves[i].win);
         check(ha, waves[i].ea);
         check(hb, waves[i].eb);
      end
      // sticky flags, masking and write-one-clear
      apb(1'b1, MODE_CTRL_OFS, 32'h0);
      apb(1'b1, WAVE_CTRL_OFS, 32'h0);
      apb(1'b0, IRQ_STATUS_OFS, 32'h0);
      check(rd, 32'h7);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, IRQ_MASK_OFS, 32'h2);
      repeat (2) @(posedge clk_i);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, IRQ_STATUS_OFS, 32'h2);
      repeat (2) @(posedge clk_i);
      check({31'h0, irq}, 32'h0);
      apb(1'b0, IRQ_STATUS_OFS, 32'h0);
      check(rd, 32'h5);
      // overflow in normal mode only when the count passes its maximum
      apb(1'b1, IRQ_STATUS_OFS, 32'h7);
      apb(1'b1, COUNT_OFS, 32'h0000fff0);
      apb(1'b1, MODE_CTRL_OFS, 32'h1);
      apb(1'b0, IRQ_STATUS_OFS, 32'h0);
      check(rd & 32'h1, 32'h0);
      repeat (20) @(posedge clk_i);
      apb(1'b0, IRQ_STATUS_OFS, 32'h0);
      check(rd & 32'h1, 32'h1);
      // reset in mid-run clears pins and every register
      resetn_i <= 1'b0;
      @(posedge clk_i);
      check({28'h0, out_a, out_b}, 32'h0);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      foreach (offs[i]) begin
         apb(1'b0, offs[i], 32'h0);
         check(rd, 32'h0);
      end
      tally_and_finish();
   end
endmodule // tb_top

// file: verification/timer16_wave_ctrl_asserts.sv
/*
 * Port-level checks of the timer waveform block.
 * Assumes one clock, one wait state on APB and pins lagging writes by two clocks.
 */
`timescale 1ns/100ps

module timer16_wave_ctrl_asserts (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // waveform pins
   input wire timer16_pkg::pin_drive_t wave_out_a_o,
   input wire timer16_pkg::pin_drive_t wave_out_b_o,
   // interrupt
   input wire logic irq_o
);
   import timer16_pkg::*;
   logic wr_done;
   logic settled;
   logic [7:0] sh_wave_reg;
   logic [3:0] sh_port_reg;
   logic [2:0] sh_mask_reg;
   logic [1:0] settle_reg;

   // =====================================================================
   // shadow of the registers that steer pins and interrupt
   assign wr_done = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
   assign settled = (settle_reg == 2'h3);
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sh_wave_reg <= 8'h00;
         sh_port_reg <= 4'h0;
         sh_mask_reg <= 3'h0;
      end else if (wr_done) begin
         if (paddr_i == WAVE_CTRL_OFS) sh_wave_reg <= pwdata_i[7:0] & WAVE_CTRL_WMASK;
         if (paddr_i == PORT_CTRL_OFS) sh_port_reg <= pwdata_i[3:0];
         if (paddr_i == IRQ_MASK_OFS) sh_mask_reg <= pwdata_i[2:0];
      end
   end
   // pins lag a write by up to two clocks, so judge them only after three
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         settle_reg <= 2'h0;
      end else if (wr_done && (paddr_i == WAVE_CTRL_OFS || paddr_i == PORT_CTRL_OFS)) begin
         settle_reg <= 2'h0;
      end else if (!settled) begin
         settle_reg <= settle_reg + 2'h1;
      end
   end

   // =====================================================================
   // properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_access;
      psel_i && $rose(penable_i);
   endsequence
   sequence s_ctrl_read;
      pready_o && !pwrite_i && paddr_i == WAVE_CTRL_OFS;
   endsequence

   a_ready_one_wait: assert property (s_access |=> pready_o)
      else $error("ready missing one cycle after access start");
   a_ready_single: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_err_with_ready: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
      else $error("slave error outside a completing access");
   a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("read data not zero outside ready");
   a_ctrl_readback: assert property (s_ctrl_read |-> prdata_o == {24'h0, sh_wave_reg})
      else $error("control register readback wrong");
   a_port_a_idle: assert property (settled && sh_wave_reg[7:6] == OM_OFF
      |-> wave_out_a_o.level == sh_port_reg[DATA_A_BIT])
      else $error("pin a not port data while channel off");
   a_port_b_idle: assert property (settled && sh_wave_reg[5:4] == OM_OFF
      |-> wave_out_b_o.level == sh_port_reg[DATA_B_BIT])
      else $error("pin b not port data while channel off");
   a_oe_from_dir: assert property (settled |-> wave_out_a_o.oe == sh_port_reg[DIR_A_BIT]
      && wave_out_b_o.oe == sh_port_reg[DIR_B_BIT])
      else $error("pin enable differs from direction bit");
   a_irq_masked: assert property (sh_mask_reg == 3'h0 && $past(sh_mask_reg) == 3'h0 |-> !irq_o)
      else $error("interrupt high with all sources masked");
endmodule // timer16_wave_ctrl_asserts

bind timer16_wave_ctrl timer16_wave_ctrl_asserts timer16_wave_ctrl_asserts_i (
   .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .wave_out_a_o(wave_out_a_o),
   .wave_out_b_o(wave_out_b_o), .irq_o(irq_o)
);
